/* File: src/sac_conv_ctrl.sv */
// Purpose: Control of an 8-bit successive-approximation converter.
// Assumes: Comparator level arrives from the analog side, asynchronous.
// Notes: Sleep and wake are one-cycle pulses from core logic on i_sys_clk.

// Operation
// - Setting go while enabled starts conversion.
// - Hardware clears go when conversion finishes.
// - Clearing go aborts, keeping partial result.
// - Go cannot be set while disabled.
// - Sleep clears go and enable, halting.
// - Sleep forces clock and channel to 11.
// - Wake or reset loads upper ones, clears low.
// - Timing comes only from the system clock.
// - Clock select picks 16, 8, 4, internal; code 11 here divides i_sys_clk by INTERNAL_OSCILLATOR_DIV_LAST plus one.
// - Pin field enables analog input pins.
// - Channel field routes one of four inputs.
// - Enable powers the converter on or off.
// - Old result readable during sampling.
// - Clear, insert marker, shift in decisions.
// - Done after eight marker shifts.
// - Marker position shows valid upper bits.
// - Sleep leaves partial data after decisions.
// - Conversion always takes thirteen bit periods.
// - Clock select change waits for next start.
// - Channel change waits for conversion end.
// - Produces an eight-bit result.
module sac_conv_ctrl #(
   parameter logic [4:0] INTERNAL_OSCILLATOR_DIV_LAST = 5'h03
) (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_sleep,
   input wire logic i_wake,
   input wire logic i_cmp_high,
   output logic o_conv_power,
   output logic o_sampling,
   output logic o_converting,
   output logic [7:0] o_trial_code,
   output logic [3:0] o_channel_onehot,
   output logic [2:0] o_analog_pin_en
);
   sac_pkg::sac_state_type r;
   sac_pkg::sac_state_type next_r;

   logic tick;
   logic req;
   logic wr_ctrl;
   logic [7:0] wval;
   logic [3:0] idx;
   logic [7:0] mask;
   logic [4:0] sel_last;

   // Bus handshake: every access is answered on the cycle after it appears.
   assign req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~r.ack;
   assign wr_ctrl = i_avs_write & r.ack & i_avs_byteenable[0] & (i_avs_address == sac_pkg::OFS_CTRL);
   assign wval = i_avs_writedata[7:0];
   // A bit period ends when the divider reaches zero.
   assign tick = (r.divcnt == 5'h00);
   assign idx = r.bit_conversion_period - sac_pkg::SAMPLE_TADS;
   assign mask = sac_pkg::MARKER_TOP >> idx[2:0];

   // Divider terminal count for the clock select field being written.
   always_comb begin
      unique case (wval[sac_pkg::POS_CLKSEL +: 2])
         2'h0: sel_last = sac_pkg::DIV16_LAST;
         2'h1: sel_last = sac_pkg::DIV8_LAST;
         2'h2: sel_last = sac_pkg::DIV4_LAST;
         2'h3: sel_last = INTERNAL_OSCILLATOR_DIV_LAST;
      endcase
   end

   // Next-state logic for the bus slave, the sequencer and the register.
   always_comb begin
      next_r = r;
      next_r.cmp_sync = {r.cmp_sync[0], i_cmp_high};
      next_r.ack = req & ~r.ack;
      if (req && !r.ack) begin
         if (i_avs_read && i_avs_address == sac_pkg::OFS_CTRL) begin
            next_r.rdata = {24'h00_0000, r.ctrl};
         end else if (i_avs_read && i_avs_address == sac_pkg::OFS_RESULT) begin
            next_r.rdata = {24'h00_0000, r.result};
         end else begin
            next_r.rdata = 32'h0000_0000;
         end
      end
      // Conversion progress, one step per bit period.
      if (r.phase != sac_pkg::PH_IDLE) begin
         if (tick) begin
            next_r.divcnt = r.div_last;
            next_r.bit_conversion_period = r.bit_conversion_period + 4'h1;
            if (r.phase == sac_pkg::PH_SAMPLE && r.bit_conversion_period == sac_pkg::SAMPLE_TADS - 4'h1) begin
               next_r.phase = sac_pkg::PH_CONVERT;
               next_r.result = sac_pkg::MARKER_TOP;
            end
            if (r.phase == sac_pkg::PH_CONVERT && r.bit_conversion_period <= sac_pkg::DECIDE_LAST) begin
               // Decided bit replaces the marker, marker moves one place down.
               next_r.result = (r.result & ~mask) | (r.cmp_sync[1] ? mask : 8'h00)
                  | (mask >> 1);
            end
            if (r.bit_conversion_period == sac_pkg::TADS_PER_CONV - 4'h1) begin
               next_r.phase = sac_pkg::PH_IDLE;
               next_r.ctrl[sac_pkg::POS_GO] = 1'b0;
            end
         end else begin
            next_r.divcnt = r.divcnt - 5'h01;
         end
      end
      // Software writes to the control register.
      if (wr_ctrl) begin
         next_r.ctrl[7:2] = wval[7:2];
         next_r.ctrl[sac_pkg::POS_ENABLE] = wval[sac_pkg::POS_ENABLE];
         if (!wval[sac_pkg::POS_ENABLE] || !wval[sac_pkg::POS_GO]) begin
            // Disable or clearing go stops at once; result is left as is.
            next_r.phase = sac_pkg::PH_IDLE;
            next_r.ctrl[sac_pkg::POS_GO] = 1'b0;
            next_r.result = r.result;
         end else if (r.phase == sac_pkg::PH_IDLE) begin
            next_r.phase = sac_pkg::PH_SAMPLE;
            next_r.ctrl[sac_pkg::POS_GO] = 1'b1;
            next_r.bit_conversion_period = 4'h0;
            next_r.div_last = sel_last;
            next_r.divcnt = sel_last;
            next_r.chan = wval[sac_pkg::POS_CHAN +: 2];
         end else begin
            next_r.ctrl[sac_pkg::POS_GO] = 1'b1;
         end
      end
      // Sleep halts and forces the fields; wake restores the reset value.
      if (i_sleep) begin
         next_r.phase = sac_pkg::PH_IDLE;
         next_r.result = r.result;
         next_r.ctrl[sac_pkg::POS_GO] = 1'b0;
         next_r.ctrl[sac_pkg::POS_ENABLE] = 1'b0;
         next_r.ctrl[sac_pkg::POS_CLKSEL +: 2] = sac_pkg::SLEEP_FIELD;
         next_r.ctrl[sac_pkg::POS_CHAN +: 2] = sac_pkg::SLEEP_FIELD;
         next_r.ctrl[sac_pkg::POS_PINCFG +: 2] = r.ctrl[sac_pkg::POS_PINCFG +: 2];
      end else if (i_wake) begin
         next_r.phase = sac_pkg::PH_IDLE;
         next_r.ctrl = sac_pkg::CTRL_RESET;
      end
      // The routed channel tracks the field only between conversions.
      if (next_r.phase == sac_pkg::PH_IDLE) begin
         next_r.chan = next_r.ctrl[sac_pkg::POS_CHAN +: 2];
      end
   end

   // State register.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         r <= sac_pkg::STATE_RESET;
      end else begin
         r <= next_r;
      end
   end

   // Outputs toward the analog front end and the bus.
   assign o_avs_readdata = r.rdata;
   assign o_conv_power = r.ctrl[sac_pkg::POS_ENABLE];
   assign o_sampling = (r.phase == sac_pkg::PH_SAMPLE);
   assign o_converting = (r.phase == sac_pkg::PH_CONVERT);
   assign o_trial_code = r.result;

   // Channel routing and analog pin enables.
   always_comb begin
      o_channel_onehot = 4'h1 << r.chan;
      unique case (r.ctrl[sac_pkg::POS_PINCFG +: 2])
         2'h0: o_analog_pin_en = 3'h0;
         2'h1: o_analog_pin_en = 3'h4;
         2'h2: o_analog_pin_en = 3'h5;
         2'h3: o_analog_pin_en = 3'h7;
      endcase
   end

   // Checks on the sequencer and register behaviour.
   sequence s_ctrl_write;
      i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
         && i_avs_address == sac_pkg::OFS_CTRL;
   endsequence

   sequence s_enter_convert;
      o_sampling ##1 o_converting;
   endsequence

   go_needs_enable_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      !r.ctrl[sac_pkg::POS_ENABLE] |-> !r.ctrl[sac_pkg::POS_GO])
      else $error("Go flag set while converter disabled.");

   start_conv_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      s_ctrl_write and (!o_sampling && !o_converting && i_avs_writedata[1:0] == 2'h3
         && !i_sleep && !i_wake) |=> o_sampling && r.ctrl[sac_pkg::POS_GO] && r.bit_conversion_period == 4'h0)
      else $error("Conversion did not start on go write.");

   done_clears_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (o_converting && tick && r.bit_conversion_period == 4'hc && !wr_ctrl) |=> !r.ctrl[sac_pkg::POS_GO]
         && r.phase == sac_pkg::PH_IDLE)
      else $error("Go flag not cleared at conversion end.");

   abort_keeps_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      s_ctrl_write and (!i_avs_writedata[1] && !i_sleep && !i_wake)
         |=> r.phase == sac_pkg::PH_IDLE && $stable(r.result))
      else $error("Abort did not stop conversion or altered result.");

   sleep_fields_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_sleep |=> r.ctrl[5:0] == 6'h3c && r.ctrl[7:6] == $past(r.ctrl[7:6]))
      else $error("Sleep did not force fields correctly.");

   wake_value_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_wake && !i_sleep) |=> r.ctrl == 8'hfc && !o_sampling && !o_converting)
      else $error("Wake did not restore control register.");

   sample_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      o_sampling ##1 o_sampling |-> $stable(r.result))
      else $error("Result changed during sampling.");

   marker_top_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      s_enter_convert |-> r.result == 8'h80)
      else $error("Result not cleared with marker at top.");

   clksel_latched_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (o_converting && !i_sleep) |=> $stable(r.div_last))
      else $error("Divisor changed during conversion.");

   bus_answer_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_avs_read || i_avs_write) |-> ##[0:1] !o_avs_waitrequest)
      else $error("Bus access not answered in time.");

   // Writing enable drives converter power on the next cycle.
   power_follows_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      s_ctrl_write and (!i_sleep && !i_wake) |=> o_conv_power == $past(i_avs_writedata[0]))
      else $error("Power does not follow written enable.");

   // A write with enable clear leaves go clear.
   go_write_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      s_ctrl_write and (!i_avs_writedata[0] && !i_sleep && !i_wake)
         |=> !r.ctrl[sac_pkg::POS_GO])
      else $error("Go set by a write with enable clear.");

   // Sleep stops every phase and powers the converter down.
   sleep_halts_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_sleep |=> !o_sampling && !o_converting && !o_conv_power && !r.ctrl[sac_pkg::POS_GO])
      else $error("Sleep did not halt the converter.");

   // Sleep leaves the partial result in place.
   sleep_result_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_sleep |=> $stable(r.result))
      else $error("Sleep altered the result.");

   // Nothing advances the result while the sequencer is idle.
   idle_result_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r.phase == sac_pkg::PH_IDLE |=> $stable(r.result))
      else $error("Result changed while idle.");

   // A running conversion never counts past its last bit period.
   tad_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r.phase != sac_pkg::PH_IDLE |-> r.bit_conversion_period <= 4'hc)
      else $error("Bit period count out of range.");

   // The divider never exceeds the latched terminal count.
   div_bound_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r.phase != sac_pkg::PH_IDLE |-> r.divcnt <= r.div_last)
      else $error("Divider above its terminal count.");

   // The divider reloads from the latched count at each period end.
   tick_reload_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (r.phase != sac_pkg::PH_IDLE && tick && !wr_ctrl && !i_sleep && !i_wake)
         |=> r.divcnt == $past(r.div_last))
      else $error("Divider did not reload.");

   // Inside a bit period the divider counts down by one.
   count_down_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (r.phase != sac_pkg::PH_IDLE && !tick && !wr_ctrl && !i_sleep && !i_wake)
         |=> r.divcnt == $past(r.divcnt) - 5'h01)
      else $error("Divider did not count down.");

   // The routed channel holds while a conversion keeps running.
   chan_frozen_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (r.phase != sac_pkg::PH_IDLE) ##1 (r.phase != sac_pkg::PH_IDLE) |-> $stable(r.chan))
      else $error("Channel changed during conversion.");

   // Between conversions the routed channel follows the field.
   chan_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r.phase == sac_pkg::PH_IDLE |-> r.chan == r.ctrl[sac_pkg::POS_CHAN +: 2])
      else $error("Idle channel does not follow the field.");

   // Exactly one input is routed at any time.
   chan_onehot_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      $onehot(o_channel_onehot))
      else $error("Channel routing not one-hot.");

   // Pin field 11 makes all three inputs analog.
   pins_all_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r.ctrl[7:6] == 2'h3 |-> o_analog_pin_en == 3'h7)
      else $error("Pin field 11 not decoded.");

   // Pin field 00 leaves every pin digital.
   pins_none_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      r.ctrl[7:6] == 2'h0 |-> o_analog_pin_en == 3'h0)
      else $error("Pin field 00 not decoded.");

   // After the last decision the result holds to the end.
   tail_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (o_converting && r.bit_conversion_period > sac_pkg::DECIDE_LAST) |=> $stable(r.result))
      else $error("Result changed after the last decision.");

   // The first decision lands in the top bit, marker moves down.
   first_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (o_converting && tick && r.bit_conversion_period == 4'h3 && !wr_ctrl && !i_sleep && !i_wake)
         |=> r.result[7] == $past(r.cmp_sync[1]) && r.result[6:0] == 7'h40)
      else $error("First decision misplaced.");

   // The last decision fills bit zero and the marker leaves.
   last_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (o_converting && tick && r.bit_conversion_period == 4'ha && !wr_ctrl && !i_sleep && !i_wake)
         |=> r.result[0] == $past(r.cmp_sync[1]))
      else $error("Last decision misplaced.");

   // A control read returns the register in the low byte.
   read_ctrl_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_avs_read && o_avs_waitrequest && i_avs_address == sac_pkg::OFS_CTRL)
         |=> o_avs_readdata == {24'h00_0000, $past(r.ctrl)})
      else $error("Control read data wrong.");

   // Unmapped reads return zero.
   read_unmapped_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_avs_read && o_avs_waitrequest && i_avs_address != sac_pkg::OFS_CTRL
         && i_avs_address != sac_pkg::OFS_RESULT) |=> o_avs_readdata == 32'h0000_0000)
      else $error("Unmapped read not zero.");

   // Every request waits exactly one cycle.
   wait_once_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
      else $error("Wait state longer than one cycle.");

   // A write without the low byte lane leaves an idle register alone.
   lane_ignored_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (i_avs_write && !o_avs_waitrequest && !i_avs_byteenable[0] && !i_sleep && !i_wake
         && r.phase == sac_pkg::PH_IDLE) |=> $stable(r.ctrl))
      else $error("Write without lane zero changed control.");

   // A running conversion always shows go and enable set.
   run_flags_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      (o_sampling || o_converting)
         |-> r.ctrl[sac_pkg::POS_GO] && r.ctrl[sac_pkg::POS_ENABLE])
      else $error("Running without go and enable.");
endmodule

/* File: src/sac_pkg.sv */
// Purpose: Shared constants and types for the converter control block.
// Assumes: One 100 MHz system clock; Avalon-MM register access.
// Notes: Byte offsets of the two registers are word aligned.
package sac_pkg;
   // Register byte offsets.
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_RESULT = 4'h4;
   // Field positions inside the control register.
   localparam int POS_ENABLE = 0;
   localparam int POS_GO = 1;
   localparam int POS_CHAN = 2;
   localparam int POS_CLKSEL = 4;
   localparam int POS_PINCFG = 6;
   // Reset and wake value: upper six bits set, go and enable clear.
   localparam logic [7:0] CTRL_RESET = 8'hfc;
   // Value forced into clock select and channel select on sleep.
   localparam logic [1:0] SLEEP_FIELD = 2'h3;
   // Terminal counts (divisor minus one) for the three divided clock select codes.
   localparam logic [4:0] DIV16_LAST = 5'h0f;
   localparam logic [4:0] DIV8_LAST = 5'h07;
   localparam logic [4:0] DIV4_LAST = 5'h03;
   // Conversion timing in bit periods.
   localparam logic [3:0] TADS_PER_CONV = 4'hd;
   localparam logic [3:0] SAMPLE_TADS = 4'h3;
   localparam logic [3:0] DECIDE_LAST = 4'ha;
   // Marker one placed at the top of the result after sampling.
   localparam logic [7:0] MARKER_TOP = 8'h80;

   typedef enum logic [1:0] {PH_IDLE, PH_SAMPLE, PH_CONVERT} sac_phase_type;

   // Whole state of the control block.
   typedef struct packed {
      sac_phase_type phase;
      logic [7:0] ctrl;
      logic [7:0] result;
      logic [3:0] bit_conversion_period;
      logic [4:0] divcnt;
      logic [4:0] div_last;
      logic [1:0] chan;
      logic ack;
      logic [31:0] rdata;
      logic [1:0] cmp_sync;
   } sac_state_type;

   localparam sac_state_type STATE_RESET = '{phase: PH_IDLE, ctrl: CTRL_RESET,
      result: 8'h00, bit_conversion_period: 4'h0, divcnt: 5'h00, div_last: DIV16_LAST, chan: 2'h3,
      ack: 1'b0, rdata: 32'h0000_0000, cmp_sync: 2'h0};
endpackage

/* File: tb/tb_sac_conv_ctrl.sv */
// Purpose: Self-checking bench for the converter control block.
// Assumes: One wait cycle per bus access; comparator level is driven directly.
// Notes: Each divide code is timed through the length of the sampling phase.
module tb_sac_conv_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_sys_clk = 1'b0, i_rstn = 1'b0, rd = 1'b0, wr = 1'b0, wreq;
   logic slp = 1'b0, wak = 1'b0, cmp = 1'b1, pwr, smp, cnv;
   logic [3:0] addr = 4'h0, be = 4'hf, chan_oh;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic [7:0] trial;
   logic seen_wreq, seen_smp, seen_cnv;
   logic [31:0] seen_rdata;
   logic [7:0] seen_trial;
   logic [2:0] pin_en;
   int err_count = 0, total_checks = 0, cycles = 0, n;
   localparam logic [2:0] PINS [4] = '{3'h0, 3'h4, 3'h5, 3'h7};
   localparam int DIVS [4] = '{16, 8, 4, 4};
   sac_conv_ctrl sac_conv_ctrl_inst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
      .i_sleep(slp), .i_wake(wak), .i_cmp_high(cmp), .o_conv_power(pwr),
      .o_sampling(smp), .o_converting(cnv), .o_trial_code(trial),
      .o_channel_onehot(chan_oh), .o_analog_pin_en(pin_en));
   // Free-running 100 MHz clock.
   initial begin
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   // Settled outputs mid-cycle, read at the next rising edge free of races.
   always @(negedge i_sys_clk) begin
      seen_wreq <= wreq;
      seen_rdata <= rdata;
      seen_smp <= smp;
      seen_cnv <= cnv;
      seen_trial <= trial;
   end
   // Prints the verdict and ends the run.
   task automatic report_and_stop();
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Cuts a hung run short.
   always @(posedge i_sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         err_count = err_count + 1;
         report_and_stop();
      end
   end
   // Compares a seen value against the expected one.
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One bus access, held until waitrequest is sampled low.
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= {24'h0, d};
      @(posedge i_sys_clk);
      while (seen_wreq !== 1'b0) @(posedge i_sys_clk);
      q = seen_rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // Counts sampling cycles and checks the marker as bit decisions begin.
   task automatic time_sampling(input int d);
      n = 0;
      while (seen_cnv !== 1'b1) begin
         @(posedge i_sys_clk);
         if (seen_smp === 1'b1) n = n + 1;
      end
      chk("sample_cycles", 32'(n), 32'(3 * d));
      chk("marker_top", {24'h0, seen_trial}, 32'h80);
   endtask
   // Polls the control register until go drops.
   task automatic wait_done();
      do acc(1'b0, 4'h0, 8'h00); while (q[1] !== 1'b0);
   endtask
   // A one-cycle pulse on sleep or wake.
   task automatic pulse(input logic s);
      @(posedge i_sys_clk);
      slp <= s;
      wak <= ~s;
      @(posedge i_sys_clk);
      slp <= 1'b0;
      wak <= 1'b0;
   endtask
   // Main sequence.
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      acc(1'b0, 4'h0, 8'h00);
      chk("ctrl_reset", q, 32'hfc);
      acc(1'b0, 4'h8, 8'h00);
      chk("unmapped", q, 32'h0);
      for (int p = 0; p < 4; p++) begin
         acc(1'b1, 4'h0, {p[1:0], 6'h3c});
         @(posedge i_sys_clk);
         chk("pin_en", {29'h0, pin_en}, {29'h0, PINS[p]});
      end
      acc(1'b1, 4'h0, 8'hfe);
      acc(1'b0, 4'h0, 8'h00);
      chk("go_disabled", q, 32'hfc);
      chk("power_off", {31'h0, pwr}, 32'h0);
      for (int s = 0; s < 4; s++) begin
         acc(1'b1, 4'h0, {2'h3, s[1:0], 4'h7});
         time_sampling(DIVS[s]);
         acc(1'b1, 4'h0, {2'h3, s[1:0], 4'hb});
         chk("chan_held", {28'h0, chan_oh}, 32'h2);
         chk("power_on", {31'h0, pwr}, 32'h1);
         wait_done();
         chk("go_cleared", q, {24'h0, 2'h3, s[1:0], 4'h9});
         acc(1'b0, 4'h4, 8'h00);
         chk("result_ones", q, 32'hff);
      end
      cmp <= 1'b0;
      acc(1'b1, 4'h0, 8'he3);
      acc(1'b0, 4'h4, 8'h00);
      chk("old_result", q, 32'hff);
      wait_done();
      acc(1'b0, 4'h4, 8'h00);
      chk("result_zeros", q, 32'h0);
      cmp <= 1'b1;
      acc(1'b1, 4'h0, 8'he3);
      time_sampling(4);
      repeat (2) @(posedge i_sys_clk);
      acc(1'b1, 4'h0, 8'he1);
      acc(1'b0, 4'h4, 8'h00);
      chk("abort_partial", q, 32'hc0);
      acc(1'b1, 4'h0, 8'h63);
      time_sampling(4);
      repeat (2) @(posedge i_sys_clk);
      pulse(1'b1);
      acc(1'b0, 4'h0, 8'h00);
      chk("sleep_ctrl", q, 32'h7c);
      chk("sleep_power", {31'h0, pwr}, 32'h0);
      repeat (8) @(posedge i_sys_clk);
      acc(1'b0, 4'h4, 8'h00);
      chk("sleep_partial", q, 32'hc0);
      pulse(1'b0);
      be <= 4'he;
      acc(1'b1, 4'h0, 8'h01);
      be <= 4'hf;
      acc(1'b0, 4'h0, 8'h00);
      chk("wake_ctrl", q, 32'hfc);
      report_and_stop();
   end
endmodule
